// file: src/cabpr_pkg.sv
// Package: constants and types of the copper base page register bank
package cabpr_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] OFS_ADV = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_LP = 5'h05;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STS = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MSK = 5'h11;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int ADV_MSB = 8;
    localparam int ADV_LSB = 5;
    localparam int SEL_MSB = 4;
    localparam int STRAP_W = 3;
    localparam int STRAP_ADV_BIT = 1;
    localparam logic [4:0] SEL_RST = 5'h01;
    localparam logic [15:0] LP_RST = 16'h0000;
    localparam int IRQ_W = 3;
    localparam int IRQ_PAGE = 0;
    localparam int IRQ_ADV = 1;
    localparam int IRQ_LINK = 2;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } cabpr_bus_t;

    typedef struct packed {
        logic sw_reset;
        logic restart_aneg;
        logic power_down;
        logic aneg_enable;
        logic speed_lsb;
        logic speed_msb;
        logic duplex;
    } cabpr_ctl_t;

    typedef struct packed {
        logic aneg_run;
        logic adv_1000_fd;
        logic adv_1000_hd;
        logic [DATA_W-1:0] base_word;
    } cabpr_adv_t;

    typedef struct packed {
        logic strap_done;
        logic [3:0] adv_pend;
        logic [3:0] adv_act;
        logic [4:0] sel;
        logic [DATA_W-1:0] lp;
        logic [DATA_W-1:0] rdata;
        logic pd_q;
        logic link_q;
        logic [IRQ_W-1:0] sts;
        logic [IRQ_W-1:0] msk;
        logic irq;
        cabpr_adv_t adv;
    } cabpr_state_t;

endpackage : cabpr_pkg

// file: src/cabpr_regs.sv
// Module: copper base page advertisement and partner ability registers
//
// Function
// - Ability writes pend until reset, restart, wake, drop
// - Forced 1000 keeps auto-negotiation running
// - Forced 1000 advertises only duplex-matched 1000BASE-T
// - Forced 1000 ignores 10/100 and 1000 bits
// - Hardware reset loads ability bits from strap
// - Ability bits 8..5: 100FD, 100HD, 10FD, 10HD
// - Selector read/write, resets 01, kept by soft reset
// - Partner word copied exactly, cleared by resets
// - Partner bit 15 shows next page ability
// - Partner bit 14 shows acknowledge
// - Partner bit 13 shows remote fault
// - Partner bit 12 raw ability bit
// - Partner bits 11/10 asymmetric pause, pause
// - Partner bits 9..5 show partner abilities
// - Partner selector in bits 4..0, resets zero
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module cabpr_regs #(
    parameter int STRAP_W = cabpr_pkg::STRAP_W
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Register port
    input wire cabpr_pkg::cabpr_bus_t bus,
    output logic [cabpr_pkg::DATA_W-1:0] rdata,
    // Strap and control bits
    input wire logic [STRAP_W-1:0] strap_autoneg_config,
    input wire cabpr_pkg::cabpr_ctl_t ctl,
    input wire logic link_up,
    input wire logic [1:0] adv_1000_bits,
    // Received base page
    input wire logic rx_page_valid,
    input wire logic [cabpr_pkg::DATA_W-1:0] rx_page_word,
    // Advertisement towards the link
    output cabpr_pkg::cabpr_adv_t adv,
    // Interrupt
    output logic irq
);

    cabpr_pkg::cabpr_state_t s_r;
    cabpr_pkg::cabpr_state_t s_nxt;
    logic forced_1000;
    logic trigger;
    logic wr_adv;
    logic [cabpr_pkg::IRQ_W-1:0] ev;

    function automatic logic hit(
        input logic [cabpr_pkg::ADDR_W-1:0] a,
        input logic [cabpr_pkg::ADDR_W-1:0] ofs
    );
        return a == ofs;
    endfunction : hit

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    // Speed select 10 with auto-negotiation off means forced 1000
    assign forced_1000 = !ctl.aneg_enable && ctl.speed_msb
        && !ctl.speed_lsb;
    // Any of the four events releases the pending ability bits
    assign trigger = ctl.sw_reset || ctl.restart_aneg
        || (s_r.pd_q && !ctl.power_down)
        || (s_r.link_q && !link_up);
    assign wr_adv = bus.wr && hit(bus.addr, cabpr_pkg::OFS_ADV);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.pd_q = ctl.power_down;
        s_nxt.link_q = link_up;
        ev = '0;
        // Strap is caught on the first clock after reset release
        if (!s_r.strap_done) begin
            s_nxt.strap_done = 1'b1;
            s_nxt.adv_pend = {4{strap_autoneg_config[
                cabpr_pkg::STRAP_ADV_BIT]}};
            s_nxt.adv_act = s_nxt.adv_pend;
        end
        if (wr_adv) begin
            s_nxt.adv_pend = bus.wdata[cabpr_pkg::ADV_MSB:
                cabpr_pkg::ADV_LSB];
            s_nxt.sel = bus.wdata[cabpr_pkg::SEL_MSB:0];
        end
        if (trigger && s_r.strap_done) begin
            s_nxt.adv_act = s_nxt.adv_pend;
            ev[cabpr_pkg::IRQ_ADV] = 1'b1;
        end
        if (s_r.link_q && !link_up) begin
            ev[cabpr_pkg::IRQ_LINK] = 1'b1;
        end
        // Whole word only, so software never sees a torn update
        if (rx_page_valid) begin
            s_nxt.lp = rx_page_word;
            ev[cabpr_pkg::IRQ_PAGE] = 1'b1;
        end
        if (ctl.sw_reset) begin
            s_nxt.lp = cabpr_pkg::LP_RST;
        end
        if (bus.wr && hit(bus.addr, cabpr_pkg::OFS_IRQ_MSK)) begin
            s_nxt.msk = bus.wdata[cabpr_pkg::IRQ_W-1:0];
        end
        // Set wins over a write-one clear in the same cycle
        s_nxt.sts = s_r.sts;
        if (bus.wr && hit(bus.addr, cabpr_pkg::OFS_IRQ_STS)) begin
            s_nxt.sts = s_r.sts & ~bus.wdata[cabpr_pkg::IRQ_W-1:0];
        end
        s_nxt.sts = s_nxt.sts | ev;
        s_nxt.irq = |(s_nxt.sts & s_nxt.msk);
        s_nxt.rdata = '0;
        if (bus.rd) begin
            unique case (1'b1)
                hit(bus.addr, cabpr_pkg::OFS_ADV): begin
                    s_nxt.rdata[cabpr_pkg::ADV_MSB:cabpr_pkg::ADV_LSB] =
                        s_r.adv_pend;
                    s_nxt.rdata[cabpr_pkg::SEL_MSB:0] = s_r.sel;
                end
                hit(bus.addr, cabpr_pkg::OFS_LP): begin
                    s_nxt.rdata = s_r.lp;
                end
                hit(bus.addr, cabpr_pkg::OFS_IRQ_STS): begin
                    s_nxt.rdata[cabpr_pkg::IRQ_W-1:0] = s_r.sts;
                end
                hit(bus.addr, cabpr_pkg::OFS_IRQ_MSK): begin
                    s_nxt.rdata[cabpr_pkg::IRQ_W-1:0] = s_r.msk;
                end
                default: begin
                    s_nxt.rdata = '0;
                end
            endcase
        end
        // Advertisement driven to the negotiation engine
        s_nxt.adv.aneg_run = ctl.aneg_enable || forced_1000;
        s_nxt.adv.base_word = '0;
        s_nxt.adv.base_word[cabpr_pkg::SEL_MSB:0] = s_nxt.sel;
        if (forced_1000) begin
            s_nxt.adv.adv_1000_fd = ctl.duplex;
            s_nxt.adv.adv_1000_hd = !ctl.duplex;
        end else begin
            s_nxt.adv.base_word[cabpr_pkg::ADV_MSB:cabpr_pkg::ADV_LSB] =
                s_nxt.adv_act;
            s_nxt.adv.adv_1000_fd = adv_1000_bits[1];
            s_nxt.adv.adv_1000_hd = adv_1000_bits[0];
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
            s_r.sel <= cabpr_pkg::SEL_RST;
            s_r.lp <= cabpr_pkg::LP_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
    assign adv = s_r.adv;
    assign irq = s_r.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_pend_hold: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        s_r.strap_done && !trigger
        |=> $stable(s_r.adv_act))
        else $error("ability bits changed without a trigger");

    chk_apply_trig: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        s_r.strap_done && trigger
        |=> s_r.adv_act == s_r.adv_pend)
        else $error("pending ability bits not applied");

    chk_restart_trig: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        s_r.strap_done && ctl.restart_aneg
        |=> s_r.adv_act == s_r.adv_pend)
        else $error("restart did not apply ability bits");

    chk_wake_trig: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        s_r.strap_done && s_r.pd_q && !ctl.power_down
        |=> s_r.adv_act == s_r.adv_pend)
        else $error("wake from power down did not apply bits");

    chk_drop_trig: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        s_r.strap_done && s_r.link_q && !link_up
        |=> s_r.adv_act == s_r.adv_pend)
        else $error("link drop did not apply ability bits");

    chk_adv_event: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        s_r.strap_done && trigger
        |=> s_r.sts[cabpr_pkg::IRQ_ADV])
        else $error("applied advertisement not flagged");

    // ------------------------------------------------------------------
    // Checks: strap, ability and selector writes
    // ------------------------------------------------------------------
    chk_strap_load: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        $rose(s_r.strap_done) |-> s_r.adv_act ==
            {4{$past(strap_autoneg_config[cabpr_pkg::STRAP_ADV_BIT])}})
        else $error("strap not loaded into ability bits");

    chk_strap_once: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        s_r.strap_done
        |=> s_r.strap_done)
        else $error("strap loaded a second time");

    chk_pend_write: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        wr_adv |=> s_r.adv_pend ==
            $past(bus.wdata[cabpr_pkg::ADV_MSB:cabpr_pkg::ADV_LSB]))
        else $error("ability write not held pending");

    chk_pend_keep: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        s_r.strap_done && !wr_adv
        |=> $stable(s_r.adv_pend))
        else $error("pending ability bits changed unwritten");

    chk_sel_write: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        wr_adv
        |=> s_r.sel == $past(bus.wdata[cabpr_pkg::SEL_MSB:0]))
        else $error("selector write lost");

    chk_sel_keep: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        ctl.sw_reset && !wr_adv
        |=> $stable(s_r.sel))
        else $error("selector lost on soft reset");

    chk_sel_hold: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        !wr_adv
        |=> $stable(s_r.sel))
        else $error("selector changed without a write");

    // ------------------------------------------------------------------
    // Checks: advertisement towards the link
    // ------------------------------------------------------------------
    chk_forced_run: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        forced_1000
        |=> adv.aneg_run)
        else $error("forced 1000 stopped auto-negotiation");

    chk_aneg_off: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        !ctl.aneg_enable && !forced_1000
        |=> !adv.aneg_run)
        else $error("auto-negotiation runs while disabled");

    chk_forced_dup: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        forced_1000 |=> adv.adv_1000_fd == $past(ctl.duplex)
            && adv.adv_1000_hd != $past(ctl.duplex))
        else $error("forced 1000 duplex advert wrong");

    chk_forced_ign: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        forced_1000 |=>
            adv.base_word[cabpr_pkg::ADV_MSB:cabpr_pkg::ADV_LSB] == 4'h0)
        else $error("forced 1000 leaks 10/100 bits");

    chk_free_1000: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        !forced_1000 |=> adv.adv_1000_fd == $past(adv_1000_bits[1])
            && adv.adv_1000_hd == $past(adv_1000_bits[0]))
        else $error("1000BASE-T advert not passed through");

    chk_free_abil: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        !forced_1000 |=>
            adv.base_word[cabpr_pkg::ADV_MSB:cabpr_pkg::ADV_LSB] == s_r.adv_act)
        else $error("advertised abilities differ from active bits");

    chk_adv_sel: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        s_r.strap_done
        |-> adv.base_word[cabpr_pkg::SEL_MSB:0] == s_r.sel)
        else $error("advertised selector differs from register");

    chk_adv_upper: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        s_r.strap_done |->
            adv.base_word[cabpr_pkg::DATA_W-1:cabpr_pkg::ADV_MSB+1] == '0)
        else $error("unused advertisement bits not zero");

    // ------------------------------------------------------------------
    // Checks: partner word
    // ------------------------------------------------------------------
    chk_lp_hold: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        !rx_page_valid && !ctl.sw_reset
        |=> $stable(s_r.lp))
        else $error("partner word changed without a page");

    chk_lp_load: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        rx_page_valid && !ctl.sw_reset
        |=> s_r.lp == $past(rx_page_word))
        else $error("complete page not loaded whole");

    chk_lp_copy: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        rx_page_valid && !ctl.sw_reset ##1 bus.rd
            && hit(bus.addr, cabpr_pkg::OFS_LP)
            |=> rdata == $past(rx_page_word, 2))
        else $error("partner word not reported bit for bit");

    chk_lp_clear: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        ctl.sw_reset
        |=> s_r.lp == cabpr_pkg::LP_RST)
        else $error("partner word not cleared by soft reset");

    chk_lp_ro: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        bus.wr && hit(bus.addr, cabpr_pkg::OFS_LP) && !rx_page_valid
            && !ctl.sw_reset |=> $stable(s_r.lp))
        else $error("software write reached the partner word");

    // ------------------------------------------------------------------
    // Checks: read port
    // ------------------------------------------------------------------
    chk_rd_idle: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        !bus.rd
        |=> rdata == '0)
        else $error("read data not zero outside a read");

    chk_rd_adv: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        bus.rd && hit(bus.addr, cabpr_pkg::OFS_ADV) |=>
            rdata[cabpr_pkg::ADV_MSB:cabpr_pkg::ADV_LSB] == $past(s_r.adv_pend)
            && rdata[cabpr_pkg::SEL_MSB:0] == $past(s_r.sel))
        else $error("advertisement read back wrong");

    chk_rd_unmap: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        bus.rd && !hit(bus.addr, cabpr_pkg::OFS_ADV)
            && !hit(bus.addr, cabpr_pkg::OFS_LP)
            && !hit(bus.addr, cabpr_pkg::OFS_IRQ_STS)
            && !hit(bus.addr, cabpr_pkg::OFS_IRQ_MSK) |=> rdata == '0)
        else $error("unmapped read not zero");

    // ------------------------------------------------------------------
    // Checks: interrupt
    // ------------------------------------------------------------------
    chk_irq_level: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        rx_page_valid && s_r.msk[cabpr_pkg::IRQ_PAGE]
            && !(bus.wr && hit(bus.addr, cabpr_pkg::OFS_IRQ_MSK))
            |=> irq)
        else $error("page event did not raise interrupt");

    chk_sts_sticky: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        s_r.sts[cabpr_pkg::IRQ_PAGE]
            && !(bus.wr && hit(bus.addr, cabpr_pkg::OFS_IRQ_STS)
            && bus.wdata[cabpr_pkg::IRQ_PAGE])
            |=> s_r.sts[cabpr_pkg::IRQ_PAGE])
        else $error("page status bit cleared by itself");

    chk_link_event: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        s_r.link_q && !link_up
        |=> s_r.sts[cabpr_pkg::IRQ_LINK])
        else $error("link drop not flagged");

endmodule : cabpr_regs

`default_nettype wire

// file: tb/cabpr_partner.sv
// Far-side model: link partner handing over base page code words
`timescale 1ns/100ps
`default_nettype none

module cabpr_partner (
    // Clock
    input wire logic clk_sys,
    // Request from the bench, slow adds one idle cycle
    input wire logic send_req,
    input wire logic slow,
    input wire logic [15:0] word,
    // Page towards the device
    output var logic rx_page_valid,
    output var logic [15:0] rx_page_word
);
    logic req_q;

    initial begin
        rx_page_valid = 1'b0;
        rx_page_word = 16'h0000;
        req_q = 1'b0;
    end

    // Whole word in one pulse; idle lines toggle so no stale copy lingers
    always @(posedge clk_sys) begin
        req_q <= send_req;
        if (slow ? req_q : send_req) begin
            rx_page_valid <= 1'b1;
            rx_page_word <= word;
        end else begin
            rx_page_valid <= 1'b0;
            rx_page_word <= ~rx_page_word;
        end
    end
endmodule : cabpr_partner

`default_nettype wire

// file: tb/cabpr_regs_tb_top.sv
// Testbench: register bank over its bus, partner pages and control triggers
`timescale 1ns/100ps
`default_nettype none

module cabpr_regs_tb_top;
    localparam logic [4:0] ADV = cabpr_pkg::OFS_ADV;
    localparam logic [4:0] LP = cabpr_pkg::OFS_LP;
    localparam logic [4:0] STS = cabpr_pkg::OFS_IRQ_STS;
    localparam logic [4:0] MSK = cabpr_pkg::OFS_IRQ_MSK;
    logic clk_sys, reset_n, link_up, irq, rx_valid, rd_q, lp_send, lp_slow;
    logic [15:0] rdata, rx_word, lp_word, w;
    logic [15:0] expq[$];
    logic [2:0] strap;
    logic [1:0] adv_1000_bits;
    logic [4:0] s;
    logic [3:0] act, na;
    cabpr_pkg::cabpr_bus_t bus_s;
    cabpr_pkg::cabpr_ctl_t ctl_s;
    cabpr_pkg::cabpr_adv_t adv;
    int mismatches, comparisons, seed;

    cabpr_regs uut (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus_s),
        .rdata(rdata), .strap_autoneg_config(strap), .ctl(ctl_s),
        .link_up(link_up), .adv_1000_bits(adv_1000_bits),
        .rx_page_valid(rx_valid), .rx_page_word(rx_word), .adv(adv),
        .irq(irq));
    cabpr_partner lp (.clk_sys(clk_sys), .send_req(lp_send), .slow(lp_slow),
        .word(lp_word), .rx_page_valid(rx_valid), .rx_page_word(rx_word));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task end_sim;
        $display("Mismatches %0d, comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    task wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus_s.addr <= a;
        bus_s.wdata <= d;
        bus_s.wr <= 1'b1;
        @(posedge clk_sys);
        bus_s.wr <= 1'b0;
    endtask : wr

    task rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        bus_s.addr <= a;
        bus_s.rd <= 1'b1;
        expq.push_back(e);
        @(posedge clk_sys);
        bus_s.rd <= 1'b0;
    endtask : rd

    // Read data stand only in the cycle after the strobe
    always @(posedge clk_sys) begin
        if (rd_q) begin
            chk(rdata, expq.pop_front());
        end
        rd_q <= bus_s.rd;
    end

    task send_page(input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        lp_word <= d;
        lp_send <= 1'b1;
        @(posedge clk_sys);
        lp_send <= 1'b0;
        while (rx_valid !== 1'b1 && n < 8) begin
            @(posedge clk_sys);
            n++;
        end
        if (n == 8) mismatches++;
    endtask : send_page

    initial begin
        #100000;
        mismatches++;
        end_sim();
    end

    // ------------------------------------------------------------------
    // Stimulus and checks
    // ------------------------------------------------------------------
    initial begin
        seed = $urandom(85377);
        reset_n = 1'b0;
        bus_s = '0;
        ctl_s = '0;
        ctl_s.aneg_enable = 1'b1;
        link_up = 1'b1;
        adv_1000_bits = 2'b00;
        rd_q = 1'b0;
        lp_send = 1'b0;
        lp_slow = 1'b0;
        lp_word = 16'h0000;
        strap = 3'($urandom);
        s = 5'h01;
        act = {4{strap[1]}};
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(ADV, {7'h00, act, s});
        rd(LP, 16'h0000);
        @(negedge clk_sys);
        chk(adv.base_word, {7'h00, act, s});
        for (int i = 0; i < 4; i++) begin
            w = 16'($urandom);
            lp_slow <= i[0];
            send_page(w);
            rd(LP, w);
            rd(LP, w);
        end
        wr(LP, ~w);
        rd(LP, w);
        rd(5'h1F, 16'h0000);
        s = 5'($urandom);
        // Soft reset, restart, wake and link drop, each must apply pending
        for (int k = 0; k < 4; k++) begin
            na = 4'($urandom);
            wr(ADV, {7'h00, na, s});
            rd(ADV, {7'h00, na, s});
            @(negedge clk_sys);
            chk(adv.base_word, {7'h00, act, s});
            @(posedge clk_sys);
            case (k)
                0: ctl_s.sw_reset <= 1'b1;
                1: ctl_s.restart_aneg <= 1'b1;
                2: ctl_s.power_down <= 1'b1;
                default: link_up <= 1'b0;
            endcase
            @(posedge clk_sys);
            ctl_s.sw_reset <= 1'b0;
            ctl_s.restart_aneg <= 1'b0;
            ctl_s.power_down <= 1'b0;
            link_up <= 1'b1;
            repeat (2) @(negedge clk_sys);
            act = na;
            chk(adv.base_word, {7'h00, act, s});
        end
        rd(ADV, {7'h00, act, s});
        rd(LP, 16'h0000);
        wr(MSK, 16'h0000);
        wr(STS, 16'h0007);
        send_page(w);
        repeat (2) @(negedge clk_sys);
        chk({15'h0000, irq}, 16'h0000);
        rd(STS, 16'h0001);
        wr(MSK, 16'h0001);
        repeat (2) @(negedge clk_sys);
        chk({15'h0000, irq}, 16'h0001);
        wr(STS, 16'h0001);
        repeat (2) @(negedge clk_sys);
        chk({15'h0000, irq}, 16'h0000);
        for (int m = 0; m < 4; m++) begin
            @(posedge clk_sys);
            ctl_s.aneg_enable <= 1'b0;
            ctl_s.speed_msb <= (m != 2);
            ctl_s.speed_lsb <= (m == 3);
            ctl_s.duplex <= m[0];
            adv_1000_bits <= 2'($urandom);
            repeat (2) @(negedge clk_sys);
            chk({15'h0000, adv.aneg_run}, {15'h0000, m < 2});
            if (m < 2) begin
                chk({14'h0000, adv.adv_1000_fd, adv.adv_1000_hd},
                    {14'h0000, m[0], ~m[0]});
                chk(adv.base_word, {7'h00, 4'h0, s});
            end else begin
                chk({14'h0000, adv.adv_1000_fd, adv.adv_1000_hd},
                    {14'h0000, adv_1000_bits});
                chk(adv.base_word, {7'h00, act, s});
            end
        end
        repeat (3) @(posedge clk_sys);
        end_sim();
    end
endmodule : cabpr_regs_tb_top

`default_nettype wire
